// ---- capture_pwm_mode_sync_control.sv ----
// Capture/auxiliary-PWM timer: mode, polarity and time-base sync control.
// Assumes an AXI4-Lite master on ref_clk and sync neighbours on the same clock.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module capture_pwm_mode_sync_control (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [capture_pwm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [capture_pwm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [capture_pwm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [capture_pwm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic incomingSync,
  output logic syncOut,
  input wire logic sharedPinIn,
  output logic sharedPinOut,
  output logic sharedPinOe
);
  import capture_pwm_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic awReady_ff, nxt_awReady, wReady_ff, nxt_wReady;
  logic bValid_ff, nxt_bValid, arReady_ff, nxt_arReady, rValid_ff, nxt_rValid;
  logic [1:0] bResp_ff, nxt_bResp, rResp_ff, nxt_rResp;
  logic [31:0] rData_ff, nxt_rData;
  logic wrFire;
  logic [9:0] wrIdx, rdIdx;
  logic wrMapped, rdMapped;
  logic [31:0] wrWord, ctlOneWord;
  logic [31:0] counter_ff, nxt_counter, phase_ff, nxt_phase;
  logic [31:0] slot_ff [4];
  logic [31:0] nxt_slot [4];
  logic [15:0] ctlOne_ff, nxt_ctlOne, ctlTwo_ff, nxt_ctlTwo;
  logic [1:0] capIdx_ff, nxt_capIdx;
  logic prevPin_ff, nxt_prevPin, syncOut_ff, nxt_syncOut, pinOe_ff, nxt_pinOe;
  logic wrCounter, wrPhase, wrCtlOne, wrCtlTwo;
  logic [3:0] wrSlot;
  logic pwmMode, polarity, syncInEn, run, loadEn, swSyncPulse, syncLoad;
  logic periodEqual, pinSynced, capEvent;
  logic [1:0] syncSel, stopWrap;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign wrFire = awHeld_ff && wHeld_ff && !bValid_ff;
  assign wrIdx = awAddr_ff[ADDR_W-1:2];
  assign rdIdx = araddr[ADDR_W-1:2];

  always_comb begin
    wrMapped = 1'b1;
    wrCounter = 1'b0;
    wrPhase = 1'b0;
    wrCtlOne = 1'b0;
    wrCtlTwo = 1'b0;
    wrSlot = 4'h0;
    case (wrIdx)
      IDX_COUNTER: wrCounter = wrFire;
      IDX_PHASE: wrPhase = wrFire;
      IDX_SLOT_ONE: wrSlot[0] = wrFire;
      IDX_SLOT_TWO: wrSlot[1] = wrFire;
      IDX_SLOT_THREE: wrSlot[2] = wrFire;
      IDX_SLOT_FOUR: wrSlot[3] = wrFire;
      IDX_CONTROL_ONE: wrCtlOne = wrFire;
      IDX_CONTROL_TWO: wrCtlTwo = wrFire;
      default: wrMapped = 1'b0;
    endcase
  end

  always_comb begin
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld = wHeld_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rResp = rResp_ff;
    nxt_rData = rData_ff;
    rdMapped = 1'b1;
    if (awvalid && awReady_ff) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = awaddr;
    end
    if (wvalid && wReady_ff) begin
      nxt_wHeld = 1'b1;
      nxt_wData = wdata;
      nxt_wStrb = wstrb;
    end
    if (bValid_ff && bready) nxt_bValid = 1'b0;
    if (wrFire) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = wrMapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (rValid_ff && rready) nxt_rValid = 1'b0;
    if (arvalid && arReady_ff) begin
      nxt_rValid = 1'b1;
      case (rdIdx)
        IDX_COUNTER: nxt_rData = counter_ff;
        IDX_PHASE: nxt_rData = phase_ff;
        IDX_SLOT_ONE: nxt_rData = slot_ff[0];
        IDX_SLOT_TWO: nxt_rData = slot_ff[1];
        IDX_SLOT_THREE: nxt_rData = slot_ff[2];
        IDX_SLOT_FOUR: nxt_rData = slot_ff[3];
        IDX_CONTROL_ONE: nxt_rData = {16'h0000, ctlOne_ff};
        IDX_CONTROL_TWO: nxt_rData = {16'h0000, ctlTwo_ff};
        default: begin
          rdMapped = 1'b0;
          nxt_rData = WORD_RESET;
        end
      endcase
      nxt_rResp = rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_awReady = !nxt_awHeld && !nxt_bValid;
    nxt_wReady = !nxt_wHeld && !nxt_bValid;
    nxt_arReady = !nxt_rValid;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= WORD_RESET;
      wStrb_ff <= 4'h0;
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rResp_ff <= RESP_OKAY;
      rData_ff <= WORD_RESET;
    end else begin
      awHeld_ff <= nxt_awHeld;
      awAddr_ff <= nxt_awAddr;
      wHeld_ff <= nxt_wHeld;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      awReady_ff <= nxt_awReady;
      wReady_ff <= nxt_wReady;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      arReady_ff <= nxt_arReady;
      rValid_ff <= nxt_rValid;
      rResp_ff <= nxt_rResp;
      rData_ff <= nxt_rData;
    end
  end

  // ----------------------------------------
  // Control fields and events
  // ----------------------------------------
  assign pwmMode = ctlTwo_ff[POS_MODE];
  assign polarity = ctlTwo_ff[POS_POLARITY];
  assign syncInEn = ctlTwo_ff[POS_SYNC_IN_EN];
  assign run = ctlTwo_ff[POS_RUN];
  assign syncSel = ctlTwo_ff[POS_SYNC_OUT_SEL +: 2];
  assign stopWrap = ctlTwo_ff[POS_STOP_WRAP +: 2];
  assign loadEn = ctlOne_ff[POS_LOAD_ENABLE];
  assign swSyncPulse = wrCtlTwo && wStrb_ff[1] && wData_ff[POS_SW_SYNC];
  assign syncLoad = syncInEn && (incomingSync || swSyncPulse);
  assign periodEqual = run && (counter_ff == slot_ff[0]);
  assign capEvent = pinSynced && !prevPin_ff;

  pin_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinRaw(sharedPinIn),
    .pinSynced(pinSynced)
  );

  pwm_wave u_pwm_wave (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(pwmMode),
    .polarity(polarity),
    .counter(counter_ff),
    .compare(slot_ff[1]),
    .pwmOut(sharedPinOut)
  );

  // ----------------------------------------
  // Time base, slots and sync chain
  // ----------------------------------------
  always_comb begin
    wrWord = merge({16'h0000, ctlTwo_ff}, wData_ff, wStrb_ff);
    ctlOneWord = merge({16'h0000, ctlOne_ff}, wData_ff, wStrb_ff);
    nxt_counter = counter_ff;
    if (syncLoad) begin
      nxt_counter = phase_ff;
    end else if (wrCounter) begin
      nxt_counter = merge(counter_ff, wData_ff, wStrb_ff);
    end else if (pwmMode && periodEqual) begin
      nxt_counter = WORD_RESET;
    end else if (run) begin
      nxt_counter = counter_ff + 32'h0000_0001;
    end
    nxt_phase = wrPhase ? merge(phase_ff, wData_ff, wStrb_ff) : phase_ff;
    nxt_ctlOne = ctlOne_ff;
    if (wrCtlOne) nxt_ctlOne = ctlOneWord[15:0] & CONTROL_ONE_MASK;
    nxt_ctlTwo = ctlTwo_ff;
    if (wrCtlTwo) nxt_ctlTwo = wrWord[15:0] & CONTROL_TWO_MASK;
    nxt_capIdx = capIdx_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_slot[i] = slot_ff[i];
      if (wrSlot[i]) begin
        nxt_slot[i] = merge(slot_ff[i], wData_ff, wStrb_ff);
      end else if (!pwmMode && loadEn && capEvent && capIdx_ff == 2'(i)) begin
        nxt_slot[i] = counter_ff;
      end
    end
    if (pwmMode && periodEqual) begin
      if (!wrSlot[0]) nxt_slot[0] = slot_ff[2];
      if (!wrSlot[1]) nxt_slot[1] = slot_ff[3];
    end
    if (!pwmMode && loadEn && capEvent) begin
      nxt_capIdx = (capIdx_ff == stopWrap) ? 2'h0 : capIdx_ff + 2'h1;
    end
    nxt_prevPin = pinSynced;
    nxt_pinOe = pwmMode;
    case (syncSel)
      SYNC_OUT_PASS: nxt_syncOut = incomingSync || swSyncPulse;
      SYNC_OUT_PERIOD: nxt_syncOut = periodEqual;
      default: nxt_syncOut = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      counter_ff <= WORD_RESET;
      phase_ff <= WORD_RESET;
      for (int i = 0; i < 4; i++) begin
        slot_ff[i] <= WORD_RESET;
      end
      ctlOne_ff <= CONTROL_ONE_RESET;
      ctlTwo_ff <= CONTROL_TWO_RESET;
      capIdx_ff <= 2'h0;
      prevPin_ff <= 1'b0;
      syncOut_ff <= 1'b0;
      pinOe_ff <= 1'b0;
    end else begin
      counter_ff <= nxt_counter;
      phase_ff <= nxt_phase;
      for (int i = 0; i < 4; i++) begin
        slot_ff[i] <= nxt_slot[i];
      end
      ctlOne_ff <= nxt_ctlOne;
      ctlTwo_ff <= nxt_ctlTwo;
      capIdx_ff <= nxt_capIdx;
      prevPin_ff <= nxt_prevPin;
      syncOut_ff <= nxt_syncOut;
      pinOe_ff <= nxt_pinOe;
    end
  end

  assign awready = awReady_ff;
  assign wready = wReady_ff;
  assign bvalid = bValid_ff;
  assign bresp = bResp_ff;
  assign arready = arReady_ff;
  assign rvalid = rValid_ff;
  assign rresp = rResp_ff;
  assign rdata = rData_ff;
  assign syncOut = syncOut_ff;
  assign sharedPinOe = pinOe_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  pwm_polarity_a: assert property (pwmMode && $stable(ctlTwo_ff) |=>
      sharedPinOut == (($past(counter_ff) < $past(slot_ff[1])) ^ $past(polarity)))
    else $error("PWM output level does not follow compare and polarity");
  capture_no_reset_a: assert property (!pwmMode && run && !syncLoad && !wrCounter
      |=> counter_ff == $past(counter_ff) + 32'h0000_0001)
    else $error("Counter did not advance in capture mode");
  period_reset_a: assert property (pwmMode && periodEqual && !syncLoad && !wrCounter
      |=> counter_ff == 32'h0000_0000)
    else $error("Counter not cleared on period match in PWM mode");
  pin_drive_a: assert property ($rose(pwmMode) |=> sharedPinOe ##1 sharedPinOe)
    else $error("Shared pin not driven in PWM mode");
  sw_sync_load_a: assert property (swSyncPulse && syncInEn
      |=> counter_ff == $past(phase_ff) && !ctlTwo_ff[POS_SW_SYNC])
    else $error("Software sync did not load phase");
  sync_out_sel_a: assert property (syncSel == SYNC_OUT_PERIOD && !wrCtlTwo
      |=> syncOut == $past(periodEqual))
    else $error("Sync out does not carry period event");
  sync_out_off_a: assert property (syncSel[1] && !wrCtlTwo |=> !syncOut ##1 1'b1)
    else $error("Sync out active while disabled");
  sync_ignore_a: assert property (!syncInEn && incomingSync && !run && !wrCounter
      && !(pwmMode && periodEqual) |=> $stable(counter_ff))
    else $error("Counter loaded while sync-in disabled");
  counter_freeze_a: assert property (!run && !syncLoad && !wrCounter
      |=> counter_ff == $past(counter_ff))
    else $error("Counter moved while frozen");
  shadow_transfer_a: assert property (pwmMode && periodEqual && wrSlot[1:0] == 2'h0
      |=> slot_ff[0] == $past(slot_ff[2]) && slot_ff[1] == $past(slot_ff[3]))
    else $error("Shadow values not transferred at period boundary");
  load_gate_a: assert property (!loadEn && wrSlot == 4'h0 && !pwmMode
      |=> slot_ff[2] == $past(slot_ff[2]) && slot_ff[3] == $past(slot_ff[3]))
    else $error("Slot loaded with capture loads disabled");
  period_pulse_a: assert property (pwmMode && periodEqual && !syncLoad && !wrCounter
      && !wrSlot[0] && slot_ff[2] != 32'h0000_0000 |=> !periodEqual)
    else $error("Period event longer than one clock");

  sw_sync_c: cover property (swSyncPulse && syncInEn);
  period_c: cover property (pwmMode && periodEqual);
  capture_c: cover property (!pwmMode && loadEn && capEvent);
  sync_pass_c: cover property (syncSel == SYNC_OUT_PASS && incomingSync ##1 syncOut);

endmodule

// ---- capture_pwm_pkg.sv ----
// Constants shared by the capture/PWM control block and its testbench.
// Assumes a 32-bit AXI4-Lite register bus and a single module clock.
package capture_pwm_pkg;

  // ----------------------------------------
  // Bus widths and responses
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [9:0] IDX_COUNTER = 10'h000;
  localparam logic [9:0] IDX_PHASE = 10'h004;
  localparam logic [9:0] IDX_SLOT_ONE = 10'h008;
  localparam logic [9:0] IDX_SLOT_TWO = 10'h00C;
  localparam logic [9:0] IDX_SLOT_THREE = 10'h010;
  localparam logic [9:0] IDX_SLOT_FOUR = 10'h014;
  localparam logic [9:0] IDX_CONTROL_ONE = 10'h028;
  localparam logic [9:0] IDX_CONTROL_TWO = 10'h02A;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_LOAD_ENABLE = 8;
  localparam int POS_POLARITY = 10;
  localparam int POS_MODE = 9;
  localparam int POS_SW_SYNC = 8;
  localparam int POS_SYNC_OUT_SEL = 6;
  localparam int POS_SYNC_IN_EN = 5;
  localparam int POS_RUN = 4;
  localparam int POS_STOP_WRAP = 1;

  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h0006;
  localparam logic [15:0] CONTROL_ONE_MASK = 16'h0100;
  localparam logic [15:0] CONTROL_TWO_MASK = 16'h06F7;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Sync-out source encodings
  // ----------------------------------------
  localparam logic [1:0] SYNC_OUT_PASS = 2'h0;
  localparam logic [1:0] SYNC_OUT_PERIOD = 2'h1;

endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for inputs that arrive from a pin.
// Assumes the inputs may change at any time relative to ref_clk.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinRaw,
  output logic [WIDTH-1:0] pinSynced
);

  logic [WIDTH-1:0] stageOne_ff;
  logic [WIDTH-1:0] stageTwo_ff;

  // ----------------------------------------
  // One pair of flops per bit
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        stageOne_ff[i] <= 1'b0;
        stageTwo_ff[i] <= 1'b0;
      end else begin
        stageOne_ff[i] <= pinRaw[i];
        stageTwo_ff[i] <= stageOne_ff[i];
      end
    end
  end

  assign pinSynced = stageTwo_ff;

endmodule

// ---- pwm_wave.sv ----
// Registered waveform of the auxiliary PWM output.
// Assumes counter and compare come from logic on the same clock.
`timescale 1ns/100ps
module pwm_wave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic polarity,
  input wire logic [31:0] counter,
  input wire logic [31:0] compare,
  output logic pwmOut
);

  logic pwmOut_ff;
  logic nxt_pwmOut;

  // ----------------------------------------
  // Compare value sets active time
  // ----------------------------------------
  always_comb begin
    nxt_pwmOut = 1'b0;
    if (enable) begin
      nxt_pwmOut = (counter < compare) ^ polarity;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwmOut_ff <= 1'b0;
    end else begin
      pwmOut_ff <= nxt_pwmOut;
    end
  end

  assign pwmOut = pwmOut_ff;

endmodule

// ---- sync_neighbour.sv ----
// Model of a neighbouring capture module on the sync chain.
// Assumes the same ref_clk as the block; fire makes a one-cycle sync pulse.
`timescale 1ns/100ps
module sync_neighbour (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic syncIn,
  output logic syncPulse,
  output logic [7:0] seenCount
);
  logic nxt_syncPulse;
  logic [7:0] nxt_seenCount;

  // ----------------------------------------
  // Pulse source and pulse counter
  // ----------------------------------------
  always_comb begin
    nxt_syncPulse = fire;
    nxt_seenCount = seenCount + {7'h00, syncIn};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncPulse <= 1'b0;
      seenCount <= 8'h00;
    end else begin
      syncPulse <= nxt_syncPulse;
      seenCount <= nxt_seenCount;
    end
  end
endmodule

// ---- tb_capture_pwm_mode_sync_control.sv ----
// Self-checking bench for the capture/PWM mode and sync control block.
// Assumes AXI4-Lite register access and sync neighbours on ref_clk.
`timescale 1ns/100ps
module tb_capture_pwm_mode_sync_control;
  import capture_pwm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sharedPinIn = 1'b0, fireUp = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, syncOut, sharedPinOut, sharedPinOe;
  logic incomingSync;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, rd2;
  logic [7:0] seenCount, seen0;
  int mismatches = 0, num_checks = 0, hiCount, expSync;

  capture_pwm_mode_sync_control u_dut (.ref_clk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .incomingSync, .syncOut, .sharedPinIn,
    .sharedPinOut, .sharedPinOe);
  sync_neighbour u_up (.ref_clk, .rst, .fire(fireUp), .syncIn(1'b0),
    .syncPulse(incomingSync), .seenCount());
  sync_neighbour u_down (.ref_clk, .rst, .fire(1'b0), .syncIn(syncOut),
    .syncPulse(), .seenCount(seenCount));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic regWrite(input logic [9:0] idx, input logic [31:0] data,
                          output logic [1:0] resp);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= data;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    // Ready stays high between transfers; only the watchdog ends a hang
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic regRead(input logic [9:0] idx, output logic [31:0] data,
                         output logic [1:0] resp);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] data);
    logic [1:0] r;
    regWrite(idx, data, r);
  endtask

  task automatic rdChk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    regRead(idx, d, r);
    check(what, d, exp);
  endtask

  task automatic fireSync();
    fireUp <= 1'b1;
    @(posedge ref_clk);
    fireUp <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pinPulse();
    sharedPinIn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sharedPinIn <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  // Twenty cycles span whole periods of ten
  task automatic pwmWindow();
    hiCount = 0;
    seen0 = seenCount;
    repeat (20) begin
      @(posedge ref_clk);
      if (sharedPinOut === 1'b1) hiCount++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdChk("control two reset", IDX_CONTROL_TWO, 32'h0000_0006);
    rdChk("counter reset", IDX_COUNTER, 32'h0000_0000);
    check("pin enable capture", {31'h0, sharedPinOe}, 32'h0);
    regWrite(10'h3FF, 32'h1, rsp);
    check("unmapped write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    regRead(10'h3FF, rd, rsp);
    check("unmapped read resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(IDX_COUNTER, 32'h0000_0010);
    repeat (5) @(posedge ref_clk);
    rdChk("frozen counter", IDX_COUNTER, 32'h0000_0010);
    wr(IDX_CONTROL_TWO, 32'h0000_0016);
    regRead(IDX_COUNTER, rd, rsp);
    repeat (3) @(posedge ref_clk);
    regRead(IDX_COUNTER, rd2, rsp);
    check("counter runs", {31'h0, rd2 > rd}, 32'h1);
    wr(IDX_CONTROL_TWO, 32'h0000_0006);
    wr(IDX_PHASE, 32'h0000_0ABC);
    wr(IDX_COUNTER, 32'h0000_0005);
    expSync = int'(seenCount);
    fireSync();
    rdChk("sync ignored", IDX_COUNTER, 32'h0000_0005);
    check("sync passed", {24'h0, seenCount}, expSync + 1);
    wr(IDX_CONTROL_TWO, 32'h0000_0026);
    fireSync();
    rdChk("sync phase load", IDX_COUNTER, 32'h0000_0ABC);
    check("sync passed", {24'h0, seenCount}, expSync + 2);
    wr(IDX_COUNTER, 32'h0000_0005);
    wr(IDX_CONTROL_TWO, 32'h0000_0126);
    rdChk("sw sync load", IDX_COUNTER, 32'h0000_0ABC);
    check("sw sync out", {24'h0, seenCount}, expSync + 3);
    rdChk("sw sync reads 0", IDX_CONTROL_TWO, 32'h0000_0026);
    for (int s = 2; s < 4; s++) begin
      wr(IDX_CONTROL_TWO, 32'h0000_0026 | (s << 6));
      fireSync();
      check("sync out off", {24'h0, seenCount}, expSync + 3);
    end
    wr(IDX_CONTROL_TWO, 32'h0000_0006);
    wr(IDX_COUNTER, 32'h0000_1234);
    wr(IDX_CONTROL_ONE, 32'h0000_0100);
    pinPulse();
    rdChk("capture slot one", IDX_SLOT_ONE, 32'h0000_1234);
    wr(IDX_CONTROL_TWO, 32'h0000_0206);
    // Output enable follows the mode one clock later
    @(posedge ref_clk);
    check("pin enable pwm", {31'h0, sharedPinOe}, 32'h1);
    pinPulse();
    rdChk("no capture in pwm", IDX_SLOT_TWO, 32'h0000_0000);
    wr(IDX_CONTROL_TWO, 32'h0000_0006);
    wr(IDX_CONTROL_ONE, 32'h0000_0000);
    pinPulse();
    rdChk("load disabled", IDX_SLOT_TWO, 32'h0000_0000);
    wr(IDX_SLOT_ONE, 32'h0000_0009);
    wr(IDX_SLOT_TWO, 32'h0000_0004);
    wr(IDX_SLOT_THREE, 32'h0000_0009);
    wr(IDX_SLOT_FOUR, 32'h0000_0004);
    wr(IDX_COUNTER, 32'h0000_0000);
    wr(IDX_CONTROL_TWO, 32'h0000_0256);
    pwmWindow();
    check("high time", hiCount, 32'd8);
    // Second period sync reaches the neighbour one clock after the window
    @(posedge ref_clk);
    check("period syncs", {24'h0, seenCount - seen0}, 32'd2);
    wr(IDX_CONTROL_TWO, 32'h0000_0656);
    pwmWindow();
    check("low time", hiCount, 32'd12);
    wr(IDX_SLOT_THREE, 32'h0000_0005);
    wr(IDX_SLOT_FOUR, 32'h0000_0002);
    repeat (30) @(posedge ref_clk);
    rdChk("period shadow", IDX_SLOT_ONE, 32'h0000_0005);
    rdChk("compare shadow", IDX_SLOT_TWO, 32'h0000_0002);
    test_done();
  end
endmodule
